// ---- shared/ptevu_pkg.sv ----
// Package with register map, field layout and constants of the pin task/event unit
//
// Behaviour
// - A channel in mode 0 takes no pin, drives nothing and raises no events.
// - A channel in mode 1 treats its pin as an input and raises its event on a matching edge.
// - A channel in mode 3 owns its pin as an output and applies set, clear and out tasks.
// - A pin owned by a task-mode channel ignores the regular GPIO output value.
// - The pin-select field picks one of pins 0 to 31 for the channel's tasks and event.
// - Polarity 0 makes the out task do nothing and raises no event.
// - Polarity 1 makes the out task drive high and raises the event on a rising edge.
// - Polarity 2 makes the out task drive low and raises the event on a falling edge.
// - Polarity 3 makes the out task toggle and raises the event on any change.
// - Entering task mode loads the initial output level; it has no effect in event mode.
// - The clear task drives the pin low and the set task drives it high, whatever the polarity.
// - Each channel has an event flag that reads 1 when the event occurred and is writable.
package ptevu_pkg;
  localparam int PTEVU_NCH = 8;
  localparam int PTEVU_NPIN = 32;
  localparam int PTEVU_AW = 12;
  // Register offsets (byte addresses)
  localparam logic [11:0] PTEVU_TASK_OUT_OFS = 12'h000;
  localparam logic [11:0] PTEVU_TASK_SET_OFS = 12'h030;
  localparam logic [11:0] PTEVU_TASK_CLR_OFS = 12'h060;
  localparam logic [11:0] PTEVU_EVT_IN_OFS = 12'h100;
  localparam logic [11:0] PTEVU_IRQ_STAT_OFS = 12'h300;
  localparam logic [11:0] PTEVU_IRQ_MASK_OFS = 12'h304;
  localparam logic [11:0] PTEVU_CFG_OFS = 12'h510;
  // Config field positions
  localparam int PTEVU_MODE_LSB = 0;
  localparam int PTEVU_PSEL_LSB = 8;
  localparam int PTEVU_POL_LSB = 16;
  localparam int PTEVU_INIT_BIT = 20;
  localparam logic [31:0] PTEVU_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] PTEVU_CFG_WMASK = 32'h0013_1f03;
  typedef enum logic [1:0] {
    PTEVU_MODE_OFF = 2'h0,
    PTEVU_MODE_EVT = 2'h1,
    PTEVU_MODE_RSV = 2'h2,
    PTEVU_MODE_TASK = 2'h3
  } ptevu_mode_t;
  typedef enum logic [1:0] {
    PTEVU_POL_NONE = 2'h0,
    PTEVU_POL_RISE = 2'h1,
    PTEVU_POL_FALL = 2'h2,
    PTEVU_POL_TOGGLE = 2'h3
  } ptevu_pol_t;
endpackage

// ---- shared/ptevu_chan_if.sv ----
// Interface carrying one channel's configuration and task strobes to its engine
`timescale 1ns/1ps
interface ptevu_chan_if;
  import ptevu_pkg::*;
  ptevu_mode_t mode;
  ptevu_pol_t pol;
  logic [4:0] psel;
  logic init_lvl;
  logic cfg_wr;
  logic task_out;
  logic task_set;
  logic task_clr;
  logic pin_in;
  logic evt;
  logic own;
  logic lvl;
  modport regs (output mode, pol, psel, init_lvl, cfg_wr, task_out, task_set, task_clr,
    output pin_in, input evt, own, lvl);
  modport eng (input mode, pol, psel, init_lvl, cfg_wr, task_out, task_set, task_clr,
    input pin_in, output evt, own, lvl);
endinterface

// ---- src/ptevu_chan.sv ----
// One channel engine: input synchroniser, edge detect and output level
`timescale 1ns/1ps
module ptevu_chan
  import ptevu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Channel
  ptevu_chan_if.eng ch
);
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic lvl_ff;
  logic nxt_lvl;
  logic base_lvl;
  logic [2:0] quiet_ff;
  logic rise;
  logic fall;
  logic is_evt;
  logic is_task;

  assign is_evt = (ch.mode == PTEVU_MODE_EVT);
  assign is_task = (ch.mode == PTEVU_MODE_TASK);
  assign rise = sync2_ff & ~prev_ff;
  assign fall = ~sync2_ff & prev_ff;
  assign base_lvl = ch.cfg_wr ? ch.init_lvl : lvl_ff;

  // Synchronise then compare against last sample
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
      quiet_ff <= 3'h0;
    end else begin
      sync1_ff <= ch.pin_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
      quiet_ff <= {quiet_ff[1:0], ch.cfg_wr};
    end
  end

  // Edge match only in event mode, held off while the chain refills after a reconfig
  always_comb begin
    ch.evt = 1'b0;
    if (is_evt && !ch.cfg_wr && (quiet_ff == 3'h0)) begin
      unique case (ch.pol)
        PTEVU_POL_NONE: ch.evt = 1'b0;
        PTEVU_POL_RISE: ch.evt = rise;
        PTEVU_POL_FALL: ch.evt = fall;
        PTEVU_POL_TOGGLE: ch.evt = rise | fall;
      endcase
    end
  end

  // Output level: a pending reload sets the base, tasks right after it still act
  always_comb begin
    nxt_lvl = base_lvl;
    if (is_task) begin
      if (ch.task_set) begin
        nxt_lvl = 1'b1;
      end else if (ch.task_clr) begin
        nxt_lvl = 1'b0;
      end else if (ch.task_out) begin
        unique case (ch.pol)
          PTEVU_POL_NONE: nxt_lvl = base_lvl;
          PTEVU_POL_RISE: nxt_lvl = 1'b1;
          PTEVU_POL_FALL: nxt_lvl = 1'b0;
          PTEVU_POL_TOGGLE: nxt_lvl = ~base_lvl;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lvl_ff <= 1'b0;
    end else begin
      lvl_ff <= nxt_lvl;
    end
  end

  assign ch.lvl = lvl_ff;
  assign ch.own = is_task;
endmodule

// ---- src/ptevu_top.sv ----
// Top of the pin task/event unit: register port, channels and pin mux
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module ptevu_top
  import ptevu_pkg::*;
#(
  parameter int NCH = PTEVU_NCH,
  parameter int NPIN = PTEVU_NPIN
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [PTEVU_AW-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Pins
  input wire logic [NPIN-1:0] PIN_IN,
  output logic [NPIN-1:0] PIN_OUT,
  output logic [NPIN-1:0] PIN_OE,
  // Regular GPIO side
  input wire logic [NPIN-1:0] GPIO_OUT,
  input wire logic [NPIN-1:0] GPIO_OE,
  // Interrupt
  output logic IRQ
);
  // Elaboration check: pin select is five bits and status holds one bit per channel
  if (NCH < 1 || NCH > 8 || NPIN != 32) begin : g_bad_param
    $error("ptevu_top: NCH must be 1..8 and NPIN must be 32");
  end

  logic [31:0] cfg_ff [NCH];
  logic [NCH-1:0] evt_ff;
  logic [NCH-1:0] mask_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic [NPIN-1:0] pin_out_ff;
  logic [NPIN-1:0] pin_oe_ff;
  logic [NCH-1:0] hit_evt;
  logic [NCH-1:0] own;
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] nxt_evt;
  logic [NCH-1:0] wr_evt;
  logic [NCH-1:0] wr_cfg;
  logic [NCH-1:0] wr_out;
  logic [NCH-1:0] wr_set;
  logic [NCH-1:0] wr_clr;
  logic [NCH-1:0] rd_cfg;
  logic [NCH-1:0] rd_evt;
  logic [31:0] rd_mux;
  logic [NPIN-1:0] nxt_pin_out;
  logic [NPIN-1:0] nxt_pin_oe;
  logic wr_stat;
  logic wr_mask;
  logic rd_stat;
  logic rd_mask;

  assign wr_stat = WR && (ADDR == PTEVU_IRQ_STAT_OFS);
  assign wr_mask = WR && (ADDR == PTEVU_IRQ_MASK_OFS);
  assign rd_stat = (ADDR == PTEVU_IRQ_STAT_OFS);
  assign rd_mask = (ADDR == PTEVU_IRQ_MASK_OFS);

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      localparam logic [11:0] OFS = 12'(gi * 4);
      ptevu_chan_if chi ();
      assign wr_cfg[gi] = WR && (ADDR == PTEVU_CFG_OFS + OFS);
      assign wr_out[gi] = WR && WDATA[0] && (ADDR == PTEVU_TASK_OUT_OFS + OFS);
      assign wr_set[gi] = WR && WDATA[0] && (ADDR == PTEVU_TASK_SET_OFS + OFS);
      assign wr_clr[gi] = WR && WDATA[0] && (ADDR == PTEVU_TASK_CLR_OFS + OFS);
      assign wr_evt[gi] = WR && (ADDR == PTEVU_EVT_IN_OFS + OFS);
      assign rd_cfg[gi] = (ADDR == PTEVU_CFG_OFS + OFS);
      assign rd_evt[gi] = (ADDR == PTEVU_EVT_IN_OFS + OFS);
      // Config fields, pin select 0..31
      assign chi.mode = ptevu_mode_t'(cfg_ff[gi][PTEVU_MODE_LSB +: 2]);
      assign chi.pol = ptevu_pol_t'(cfg_ff[gi][PTEVU_POL_LSB +: 2]);
      assign chi.psel = cfg_ff[gi][PTEVU_PSEL_LSB +: 5];
      assign chi.init_lvl = cfg_ff[gi][PTEVU_INIT_BIT];
      assign chi.task_out = wr_out[gi];
      assign chi.task_set = wr_set[gi];
      assign chi.task_clr = wr_clr[gi];
      assign chi.pin_in = PIN_IN[chi.psel];
      // Config write reloads the level on the following cycle
      logic cfg_wr_ff;
      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          cfg_wr_ff <= 1'b0;
        end else begin
          cfg_wr_ff <= wr_cfg[gi];
        end
      end
      assign chi.cfg_wr = cfg_wr_ff;
      assign hit_evt[gi] = chi.evt;
      assign own[gi] = chi.own;
      assign lvl[gi] = chi.lvl;
      ptevu_chan u_chan (
        .clock(CLOCK),
        .rst(SYS_RST),
        .ch(chi.eng)
      );
      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          cfg_ff[gi] <= PTEVU_CFG_RST;
        end else if (wr_cfg[gi]) begin
          cfg_ff[gi] <= WDATA & PTEVU_CFG_WMASK;
        end
      end
    end
  endgenerate

  // Event flags: write-1-clear in status, direct write at the flag; set wins
  always_comb begin
    nxt_evt = evt_ff;
    for (int i = 0; i < NCH; i++) begin
      if (wr_evt[i]) begin
        nxt_evt[i] = WDATA[0];
      end
      if (wr_stat && WDATA[i]) begin
        nxt_evt[i] = 1'b0;
      end
      if (hit_evt[i]) begin
        nxt_evt[i] = 1'b1;
      end
    end
  end

  // Pin mux: task-mode channel overrides regular GPIO; later task channel wins a clash, an event-mode channel always turns the enable off
  always_comb begin
    nxt_pin_out = GPIO_OUT;
    nxt_pin_oe = GPIO_OE;
    for (int i = 0; i < NCH; i++) begin
      if (own[i]) begin
        nxt_pin_out[cfg_ff[i][PTEVU_PSEL_LSB +: 5]] = lvl[i];
        nxt_pin_oe[cfg_ff[i][PTEVU_PSEL_LSB +: 5]] = 1'b1;
      end
    end
    for (int i = 0; i < NCH; i++) begin
      if (chi_is_evt(cfg_ff[i])) begin
        nxt_pin_oe[cfg_ff[i][PTEVU_PSEL_LSB +: 5]] = 1'b0;
      end
    end
  end

  function automatic logic chi_is_evt(input logic [31:0] c);
    chi_is_evt = (c[PTEVU_MODE_LSB +: 2] == PTEVU_MODE_EVT);
  endfunction

  // Read data selection; unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NCH; i++) begin
      if (rd_cfg[i]) begin
        rd_mux = cfg_ff[i];
      end
      if (rd_evt[i]) begin
        rd_mux = {31'h0000_0000, evt_ff[i]};
      end
    end
    if (rd_stat) begin
      rd_mux = 32'(evt_ff);
    end
    if (rd_mask) begin
      rd_mux = 32'(mask_ff);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      evt_ff <= '0;
      mask_ff <= '0;
      rdata_ff <= 32'h0000_0000;
      irq_ff <= 1'b0;
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
    end else begin
      evt_ff <= nxt_evt;
      if (wr_mask) begin
        mask_ff <= WDATA[NCH-1:0];
      end
      rdata_ff <= RD ? rd_mux : 32'h0000_0000;
      irq_ff <= |(nxt_evt & mask_ff);
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign RDATA = rdata_ff;
  assign IRQ = irq_ff;
  assign PIN_OUT = pin_out_ff;
  assign PIN_OE = pin_oe_ff;
endmodule

// ---- verif/ptevu_sva.sv ----
// Port checker of the pin task/event unit
`timescale 1ns/1ps
module ptevu_sva
  import ptevu_pkg::*;
#(
  parameter int NCH = 8,
  parameter int NPIN = 32
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [PTEVU_AW-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // Pins and GPIO
  input wire logic [NPIN-1:0] PIN_IN,
  input wire logic [NPIN-1:0] PIN_OUT,
  input wire logic [NPIN-1:0] PIN_OE,
  input wire logic [NPIN-1:0] GPIO_OUT,
  input wire logic [NPIN-1:0] GPIO_OE,
  input wire logic IRQ
);
  logic [31:0] cfg_ff;
  logic [NPIN-1:0] gpo_ff;
  logic [NPIN-1:0] gpoe_ff;
  wire logic [4:0] psel = cfg_ff[12:8];
  wire logic set_wr = WR && ADDR == PTEVU_TASK_SET_OFS && WDATA[0];
  wire logic clr_wr = WR && ADDR == PTEVU_TASK_CLR_OFS && WDATA[0];
  always_ff @(posedge CLOCK) begin
    gpo_ff <= GPIO_OUT;
    gpoe_ff <= GPIO_OE;
    if (SYS_RST) cfg_ff <= '0;
    else if (WR && ADDR == PTEVU_CFG_OFS) cfg_ff <= WDATA & PTEVU_CFG_WMASK;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_task_held;
    (cfg_ff[1:0] == 2'h3 && $stable(cfg_ff)) [*3];
  endsequence
  sequence s_off_held;
    (cfg_ff[1:0] == 2'h0 && $stable(cfg_ff)) [*2];
  endsequence
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside read cycle");
  a_reset_quiet: assert property ($fell(SYS_RST) |-> !IRQ && PIN_OE == '0)
    else $error("outputs active after reset");
  a_cfg_reserved: assert property (RD && ADDR >= PTEVU_CFG_OFS && ADDR <= 12'h52c
    |=> (RDATA & 32'hffec_e0fc) == 32'h0) else $error("config spare bits set");
  a_set_high: assert property (set_wr && cfg_ff[1:0] == 2'h3 |=> ##1 PIN_OUT[psel])
    else $error("set task missed");
  a_clr_low: assert property (clr_wr && cfg_ff[1:0] == 2'h3 |=> ##1 !PIN_OUT[psel])
    else $error("clear task missed");
  a_own_pin: assert property (s_task_held |-> PIN_OE[psel])
    else $error("task pin not driven");
  a_gpio_pass: assert property (s_off_held |-> PIN_OUT[psel] == gpo_ff[psel]
    && PIN_OE[psel] == gpoe_ff[psel]) else $error("free pin not from GPIO");
  a_init_level: assert property (WR && ADDR == PTEVU_CFG_OFS && WDATA[1:0] == 2'h3
    |=> ##2 PIN_OUT[psel] == cfg_ff[20]) else $error("initial level wrong");
endmodule
bind ptevu_top ptevu_sva #(.NCH(NCH), .NPIN(NPIN)) i_sva (.CLOCK, .SYS_RST, .ADDR, .WDATA,
  .WR, .RD, .RDATA, .PIN_IN, .PIN_OUT, .PIN_OE, .GPIO_OUT, .GPIO_OE, .IRQ);

// ---- verif/ptevu_pads.sv ----
// Pads and external drivers around the unit
`timescale 1ns/1ps
module ptevu_pads (
  // Unit side
  input wire logic [31:0] PIN_OUT,
  input wire logic [31:0] PIN_OE,
  output logic [31:0] PIN_IN,
  // External source
  input wire logic [31:0] EXT_LVL
);
  // A driven pad reads back its own level
  assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & EXT_LVL);
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench of the pin task/event unit
`timescale 1ns/1ps
module tb_top;
  import ptevu_pkg::*;
  logic CLOCK, SYS_RST, WR, RD, IRQ;
  logic [11:0] ADDR;
  logic [31:0] WDATA, RDATA, PIN_IN, PIN_OUT, PIN_OE, GPIO_OUT, GPIO_OE, ext;
  int err_count, comparisons;
  ptevu_top i_dut (.CLOCK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .PIN_IN, .PIN_OUT,
    .PIN_OE, .GPIO_OUT, .GPIO_OE, .IRQ);
  ptevu_pads i_pads (.PIN_OUT, .PIN_OE, .PIN_IN, .EXT_LVL(ext));
  initial begin
    CLOCK = 0;
    forever #2 CLOCK = ~CLOCK;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: word %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 chk_w(RDATA, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic pin9(input logic v);
    @(posedge CLOCK);
    ext[9] <= v;
    settle(6);
  endtask
  task automatic t_regs;
    rd(PTEVU_CFG_OFS, 32'h0);
    rd(12'hffc, 32'h0);
    wr(12'h52c, 32'hffff_ffff);
    rd(12'h52c, 32'h0013_1f03);
    wr(12'h52c, 32'h0);
  endtask
  task automatic t_task;
    logic [1:0] pol;
    for (int p = 0; p < 4; p++) begin
      pol = p[1:0];
      wr(PTEVU_CFG_OFS, {11'h0, ~pol[0], 2'h0, pol, 8'h05, 8'h03});
      settle(3);
      chk_b(PIN_OUT[5], ~pol[0]);
      chk_b(PIN_OE[5], 1'b1);
      wr(PTEVU_TASK_OUT_OFS, 32'h1);
      settle(2);
      chk_b(PIN_OUT[5], 1'(4'b1011 >> pol));
    end
    wr(PTEVU_TASK_CLR_OFS, 32'h1);
    settle(2);
    chk_b(PIN_OUT[5], 1'b0);
    wr(PTEVU_TASK_SET_OFS, 32'h1);
    settle(2);
    chk_b(PIN_OUT[5], 1'b1);
  endtask
  task automatic t_off;
    wr(PTEVU_CFG_OFS, 32'h0000_0500);
    @(posedge CLOCK);
    GPIO_OUT[5] <= 1'b0;
    settle(3);
    chk_b(PIN_OUT[5], 1'b0);
    wr(PTEVU_TASK_SET_OFS, 32'h1);
    settle(2);
    chk_b(PIN_OUT[5], 1'b0);
  endtask
  task automatic t_event;
    logic [1:0] pol;
    logic on;
    for (int k = 0; k < 5; k++) begin
      pol = k[1:0];
      on = k < 4;
      wr(12'h514, {14'h0, pol, 3'h0, 5'h09, 7'h0, on});
      wr(PTEVU_IRQ_STAT_OFS, 32'h2);
      pin9(1'b1);
      rd(12'h104, {31'h0, on & pol[0]});
      chk_b(IRQ, on & pol[0]);
      chk_b(PIN_OE[9], ~on);
      wr(12'h104, 32'h0);
      pin9(1'b0);
      rd(12'h104, {31'h0, on & pol[1]});
    end
  endtask
  task automatic t_irq;
    wr(12'h514, 32'h0003_0901);
    wr(PTEVU_IRQ_STAT_OFS, 32'h2);
    pin9(1'b1);
    chk_b(IRQ, 1'b1);
    wr(PTEVU_IRQ_MASK_OFS, 32'h0);
    settle(2);
    chk_b(IRQ, 1'b0);
    rd(PTEVU_IRQ_STAT_OFS, 32'h2);
    wr(PTEVU_IRQ_MASK_OFS, 32'h2);
    settle(2);
    chk_b(IRQ, 1'b1);
    wr(PTEVU_IRQ_STAT_OFS, 32'h2);
    settle(2);
    chk_b(IRQ, 1'b0);
    rd(12'h104, 32'h0);
    wr(12'h104, 32'h1);
    rd(12'h104, 32'h1);
  endtask
  initial begin
    SYS_RST = 1;
    WR = 0;
    RD = 0;
    ADDR = '0;
    WDATA = '0;
    GPIO_OUT = '1;
    GPIO_OE = '1;
    ext = '0;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    t_regs;
    t_task;
    t_off;
    wr(PTEVU_IRQ_MASK_OFS, 32'h2);
    t_event;
    t_irq;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    err_count++;
    final_report;
  end
endmodule
